// ---- src/flash_pkg.sv ----
// Shared constants and types for the burst flash device model
package flash_pkg;
	localparam int ADDR_W = 25;
	localparam int DATA_W = 16;
	localparam int MEM_AW = 14;
	localparam int BANK_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int WBUF_BYTES = 64;
	localparam int WBUF_WORDS = WBUF_BYTES / 2;
	localparam int WBUF_AW = 5;
	localparam int SYNC_W = 54;
	localparam int BOOT_SECTORS = 4;
	localparam int BOOT_SECT_KB = 32;
	localparam int MAIN_SECT_KB = 128;
	localparam int BOOT_SECT_WORDS = BOOT_SECT_KB * 1024 / 2;
	localparam int MAIN_SECT_WORDS = MAIN_SECT_KB * 1024 / 2;
	localparam int AMAX_LARGE = 24;
	localparam int AMAX_MID = 23;
	localparam int AMAX_SMALL = 22;
	localparam int WRAP8_LEN = 8;
	localparam int WRAP16_LEN = 16;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [15:0] BUSY_READ_WORD = 16'h0000;
	localparam logic [15:0] PROG_KEY = 16'h0029;
	localparam logic [15:0] ERASE_KEY = 16'h0030;

	typedef enum logic [1:0] {
		DENS_SMALL = 2'h0,
		DENS_MID = 2'h1,
		DENS_LARGE = 2'h2
	} density_t;

	typedef enum logic [1:0] {
		BURST_CONT = 2'h0,
		BURST_WRAP8 = 2'h1,
		BURST_WRAP16 = 2'h2
	} burst_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PROG = 3'b010,
		ST_ERASE = 3'b100
	} op_state_t;
endpackage

// ---- src/burst_fifo.sv ----
// Synchronous word FIFO between array fetch and the data pins
`timescale 1ns/100ps
module burst_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // burst_fifo

// ---- src/burst_counter.sv ----
// Burst address counter: continuous, or wrapped in 8/16-word groups
`timescale 1ns/100ps
module burst_counter (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control
	input wire logic load_i,
	input wire logic [flash_pkg::ADDR_W-1:0] load_addr_i,
	input wire flash_pkg::burst_t mode_i,
	input wire logic advance_i,
	// Status
	output logic [flash_pkg::ADDR_W-1:0] addr_o,
	output logic more_o
);
	import flash_pkg::*;
	logic [ADDR_W-1:0] start;
	logic [4:0] offs;
	burst_t mode;
	logic more;
	wire [4:0] len = (mode == BURST_WRAP8) ? 5'(WRAP8_LEN) : 5'(WRAP16_LEN);
	wire [4:0] low = 5'(start[3:0]) + offs;
	wire [3:0] wrap_low = (mode == BURST_WRAP8) ?
		{start[3], low[2:0]} : low[3:0];

	// Wrapped bursts stay in the aligned group and stop before the start
	assign addr_o = (mode == BURST_CONT) ? start + ADDR_W'(offs) :
		{start[ADDR_W-1:4], wrap_low};
	assign more_o = more;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start <= '0;
			offs <= '0;
			mode <= BURST_CONT;
			more <= 1'b0;
		end else if (load_i) begin
			start <= load_addr_i;
			offs <= '0;
			mode <= mode_i;
			more <= 1'b1;
		end else if (advance_i && more) begin
			if (mode == BURST_CONT) begin
				start <= start + 1'b1;
			end else begin
				offs <= offs + 1'b1;
				more <= (offs + 1'b1) != len;
			end
		end
	end
endmodule // burst_counter

// ---- src/flash_device.sv ----
// Banked burst NOR flash: pin interface, burst engine, program and erase
`timescale 1ns/100ps
module flash_device (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Bus strobes
	input wire logic link_clk_i,
	input wire logic address_valid_n_i,
	input wire logic first_select_n_i,
	input wire logic second_select_n_i,
	input wire logic output_enable_n_i,
	input wire logic write_enable_n_i,
	input wire logic hw_reset_n_i,
	input wire logic protect_accel_in_i,
	output logic ready_o,
	// Address and data
	input wire logic [flash_pkg::ADDR_W-1:0] addr_i,
	input wire logic [flash_pkg::DATA_W-1:0] data_pins_i,
	output logic [flash_pkg::DATA_W-1:0] data_pins_o,
	output logic data_pins_oe_n_o,
	// Model straps
	input wire flash_pkg::burst_t burst_mode_i,
	input wire flash_pkg::density_t density_i,
	input wire logic boot_top_i
);
	import flash_pkg::*;

	function automatic int amax_of(input density_t d);
		case (d)
			DENS_LARGE: amax_of = AMAX_LARGE;
			DENS_MID: amax_of = AMAX_MID;
			default: amax_of = AMAX_SMALL;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] dens_mask(input density_t d);
		dens_mask = ADDR_W'((33'h1 << (amax_of(d) + 1)) - 33'h1);
	endfunction

	function automatic logic [BANK_W-1:0] bank_of(
		input logic [ADDR_W-1:0] a, input density_t d);
		bank_of = BANK_W'(a >> (amax_of(d) - 3));
	endfunction

	// Pin synchroniser: two flops, only the second stage is read
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// Link clock resets to its idle low so no false edge follows
			sync1 <= {{SYNC_W-33{1'b0}}, 25'h0, 8'h7e};
			sync2 <= {{SYNC_W-33{1'b0}}, 25'h0, 8'h7e};
		end else begin
			sync1 <= {boot_top_i, density_i, burst_mode_i, data_pins_i,
				addr_i, link_clk_i, address_valid_n_i, first_select_n_i,
				second_select_n_i, output_enable_n_i, write_enable_n_i,
				hw_reset_n_i, protect_accel_in_i};
			sync2 <= sync1;
		end
	end

	wire lk_s = sync2[7];
	wire avd_n_s = sync2[6];
	wire sel1_n_s = sync2[5];
	wire sel2_n_s = sync2[4];
	wire oe_n_s = sync2[3];
	wire we_n_s = sync2[2];
	wire hwrst_n_s = sync2[1];
	wire protect_s = sync2[0];
	wire [ADDR_W-1:0] addr_s = sync2[32:8];
	wire [DATA_W-1:0] data_s = sync2[48:33];
	wire [1:0] burst_s = sync2[50:49];
	wire [1:0] dens_s = sync2[52:51];
	wire boot_s = sync2[53];

	// Straps are caught after reset release, not by the reset itself
	// Wait two edges so the synchroniser holds pins, not its reset value
	logic strap_done;
	logic [1:0] strap_wait;
	density_t density;
	logic boot_top;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strap_done <= 1'b0;
			strap_wait <= 2'h0;
			density <= DENS_SMALL;
			boot_top <= 1'b0;
		end else if (!strap_done) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == 2'h2) begin
				strap_done <= 1'b1;
				density <= density_t'(dens_s);
				boot_top <= boot_s;
			end
		end
	end

	// Edge detection on synchronised strobes
	logic lk_prev;
	logic we_prev;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lk_prev <= 1'b0;
			we_prev <= 1'b1;
		end else begin
			lk_prev <= lk_s;
			we_prev <= we_n_s;
		end
	end
	wire lk_rise = lk_s && !lk_prev;
	wire we_rise = we_n_s && !we_prev;

	// Each select maps one half of the density's address space
	wire sel1 = !sel1_n_s;
	wire sel2 = !sel2_n_s;
	wire selected = sel1 || sel2;
	wire [ADDR_W-1:0] amask = dens_mask(density);
	wire [ADDR_W-1:0] half_bit = ADDR_W'(1) << amax_of(density);
	wire [ADDR_W-1:0] eff_addr = (addr_s & amask & ~half_bit) |
		(sel2 ? half_bit : '0);

	// Array model: a window of the array, aliased by the low address bits
	logic [DATA_W-1:0] mem [2**MEM_AW];
	initial begin
		for (int i = 0; i < 2**MEM_AW; i++)
			mem[i] = ERASED_WORD;
	end

	op_state_t state;
	logic [BANK_W-1:0] busy_bank;
	wire busy = (state != ST_IDLE);

	function automatic logic [DATA_W-1:0] rd_word(
		input logic [ADDR_W-1:0] a, input logic b,
		input logic [BANK_W-1:0] bb, input density_t d);
		rd_word = (b && bank_of(a, d) == bb) ? BUSY_READ_WORD :
			mem[a[MEM_AW-1:0]];
	endfunction

	// Hardware reset pin acts as a functional reset of bursts, program, erase and the write buffer; async reads still drive
	wire func_rst = !hwrst_n_s || !strap_done;

	// Burst engine
	logic burst_active;
	logic first_done;
	logic [ADDR_W-1:0] async_addr;
	logic [DATA_W-1:0] data_q;
	wire [ADDR_W-1:0] ctr_addr;
	wire ctr_more;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [DATA_W-1:0] fifo_out_data;
	wire capture = lk_rise && !avd_n_s && selected;
	wire fetch = burst_active && ctr_more && fifo_in_ready && !capture;
	wire pop = burst_active && lk_rise && avd_n_s && fifo_out_valid;
	wire [DATA_W-1:0] fetch_word =
		rd_word(ctr_addr & amask, busy, busy_bank, density);

	burst_counter u_counter (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.load_i(capture),
		.load_addr_i(eff_addr),
		.mode_i(burst_t'(burst_s)),
		.advance_i(fetch),
		.addr_o(ctr_addr),
		.more_o(ctr_more)
	);

	// Prefetch buffer lets the array run ahead of the host's clock
	burst_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.flush_i(capture || func_rst),
		.in_valid_i(fetch),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fetch_word),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			burst_active <= 1'b0;
			first_done <= 1'b0;
		end else if (func_rst || !selected) begin
			burst_active <= 1'b0;
			first_done <= 1'b0;
		end else if (capture) begin
			burst_active <= 1'b1;
			first_done <= 1'b0;
		end else if (pop) begin
			first_done <= 1'b1;
		end
	end

	// Async address follows pins while AVD is low and the clock is low
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			async_addr <= '0;
		else if (!avd_n_s && !lk_s && selected && !burst_active)
			async_addr <= eff_addr;
	end

	// Every read delivers a full word
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			data_q <= '0;
		else if (pop)
			data_q <= fifo_out_data;
		else if (!burst_active)
			data_q <= rd_word(async_addr, busy, busy_bank, density);
	end

	assign data_pins_o = data_q;
	// Drive tracks the output strobe with no reference to the link clock
	assign data_pins_oe_n_o = !(!oe_n_s && selected && we_n_s);
	assign ready_o = burst_active && fifo_out_valid;

	// Write buffer: one aligned 32-word group, bit-AND into the array
	logic [DATA_W-1:0] wbuf [WBUF_WORDS];
	logic [WBUF_WORDS-1:0] wvalid;
	logic [ADDR_W-WBUF_AW-1:0] wgroup;
	logic [ADDR_W-1:0] op_addr;
	logic [ADDR_W-1:0] op_left;
	logic [WBUF_AW-1:0] prog_idx;
	wire wr_take = we_rise && selected && avd_n_s;
	wire [ADDR_W-1:0] waddr = async_addr;
	wire [WBUF_AW-1:0] woff = waddr[WBUF_AW-1:0];
	wire is_erase = (data_s == ERASE_KEY);
	wire is_prog = (data_s == PROG_KEY);
	wire allowed = protect_s && !busy;
	wire start_prog = wr_take && is_prog && allowed && (wvalid != '0);
	wire start_erase = wr_take && is_erase && allowed;
	wire load_word = wr_take && !is_prog && !is_erase && allowed;

	// Sector geometry: four small boot sectors at one end of the array
	wire [ADDR_W-1:0] boot_span = ADDR_W'(BOOT_SECTORS * BOOT_SECT_WORDS);
	wire [ADDR_W-1:0] top_base = (amask + 1'b1) - boot_span;
	wire in_boot = boot_top ? (waddr >= top_base) : (waddr < boot_span);
	wire [ADDR_W-1:0] sect_words = in_boot ? ADDR_W'(BOOT_SECT_WORDS) :
		ADDR_W'(MAIN_SECT_WORDS);
	wire [ADDR_W-1:0] sect_base = waddr & ~(sect_words - 1'b1);
	// Only the modelled window can be cleared, so the walk is capped
	wire [ADDR_W-1:0] walk_len = (sect_words > ADDR_W'(2**MEM_AW)) ?
		ADDR_W'(2**MEM_AW) : sect_words;

	always_ff @(posedge clk_i) begin
		if (load_word)
			wbuf[woff] <= data_s;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wvalid <= '0;
			wgroup <= '0;
		end else if (func_rst || start_prog || (wr_take && !protect_s)) begin
			wvalid <= '0;
		end else if (load_word) begin
			wgroup <= waddr[ADDR_W-1:WBUF_AW];
			if (waddr[ADDR_W-1:WBUF_AW] != wgroup)
				wvalid <= WBUF_WORDS'(1) << woff;
			else
				wvalid <= wvalid | (WBUF_WORDS'(1) << woff);
		end
	end

	// Program and erase walks; one bank stays busy, others remain readable
	logic [WBUF_WORDS-1:0] prog_mask;
	logic [DATA_W-1:0] prog_data [WBUF_WORDS];
	always_ff @(posedge clk_i) begin
		if (start_prog) begin
			for (int i = 0; i < WBUF_WORDS; i++)
				prog_data[i] <= wbuf[i];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_IDLE;
			busy_bank <= '0;
			op_addr <= '0;
			op_left <= '0;
			prog_idx <= '0;
			prog_mask <= '0;
		end else if (func_rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_prog) begin
						state <= ST_PROG;
						op_addr <= {wgroup, {WBUF_AW{1'b0}}};
						busy_bank <= bank_of({wgroup, {WBUF_AW{1'b0}}}, density);
						prog_idx <= '0;
						prog_mask <= wvalid;
					end else if (start_erase) begin
						state <= ST_ERASE;
						op_addr <= sect_base;
						op_left <= walk_len;
						busy_bank <= bank_of(sect_base, density);
					end
				end
				ST_PROG: begin
					prog_idx <= prog_idx + 1'b1;
					if (prog_idx == WBUF_AW'(WBUF_WORDS - 1))
						state <= ST_IDLE;
				end
				ST_ERASE: begin
					op_addr <= op_addr + 1'b1;
					op_left <= op_left - 1'b1;
					if (op_left == ADDR_W'(1))
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	wire [ADDR_W-1:0] prog_addr = op_addr | ADDR_W'(prog_idx);
	wire prog_we = (state == ST_PROG) && prog_mask[prog_idx] && !func_rst;
	wire erase_we = (state == ST_ERASE) && !func_rst;

	// Programming can only clear bits; erase brings them back to one
	// Plain always: the array is also preset to ones at start-up
	always @(posedge clk_i) begin
		if (prog_we)
			mem[prog_addr[MEM_AW-1:0]] <=
				mem[prog_addr[MEM_AW-1:0]] & prog_data[prog_idx];
		else if (erase_we)
			mem[op_addr[MEM_AW-1:0]] <= ERASED_WORD;
	end
endmodule // flash_device

// ---- tb/flash_device_assertions.sv ----
// Pin-level checks for the burst flash device
`timescale 1ns/100ps
module flash_device_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Bus pins
	input wire logic link_clk_i,
	input wire logic address_valid_n_i,
	input wire logic first_select_n_i,
	input wire logic second_select_n_i,
	input wire logic output_enable_n_i,
	input wire logic hw_reset_n_i,
	input wire logic ready_o,
	input wire logic [flash_pkg::DATA_W-1:0] data_pins_o,
	input wire logic data_pins_oe_n_o
);
	import flash_pkg::*;
	logic [3:0] avd_age;
	logic [3:0] link_age;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Ages saturate so a long idle never wraps back into the window
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			avd_age <= 4'hf;
			link_age <= 4'hf;
		end else begin
			avd_age <= !address_valid_n_i ? 4'h0 :
				avd_age + {3'h0, avd_age != 4'hf};
			link_age <= link_clk_i ? 4'h0 :
				link_age + {3'h0, link_age != 4'hf};
		end
	end
	sequence s_oe_off;
		output_enable_n_i[*3];
	endsequence
	sequence s_burst_hold;
		(ready_o && address_valid_n_i && !link_clk_i)[*6];
	endsequence
	sequence s_desel;
		(first_select_n_i && second_select_n_i)[*5];
	endsequence
	sequence s_hw_reset;
		(!hw_reset_n_i)[*5];
	endsequence
	a_oe_follows_pin: assert property (!data_pins_oe_n_o |->
		!$past(output_enable_n_i, 2)) else $error("data driven without enable");
	a_oe_release: assert property (s_oe_off |-> data_pins_oe_n_o)
		else $error("data still driven after enable released");
	a_oe_needs_select: assert property (!data_pins_oe_n_o |->
		!($past(first_select_n_i, 2) && $past(second_select_n_i, 2)))
		else $error("data driven while deselected");
	a_desel_no_ready: assert property (s_desel |-> !ready_o)
		else $error("ready high while deselected");
	a_hw_reset_idle: assert property (s_hw_reset |-> !ready_o)
		else $error("ready high during hardware reset");
	a_ready_after_capture: assert property ($rose(ready_o) |->
		avd_age < 4'hc) else $error("ready rose without address strobe");
	a_ready_after_link: assert property ($rose(ready_o) |->
		link_age < 4'hc) else $error("ready rose without link edge");
	a_burst_stall: assert property (s_burst_hold |->
		$stable(data_pins_o)) else $error("burst word moved without edge");
endmodule // flash_device_assertions

bind flash_device flash_device_assertions i_checker (
	.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
	.address_valid_n_i(address_valid_n_i),
	.first_select_n_i(first_select_n_i),
	.second_select_n_i(second_select_n_i),
	.output_enable_n_i(output_enable_n_i), .hw_reset_n_i(hw_reset_n_i),
	.ready_o(ready_o), .data_pins_o(data_pins_o),
	.data_pins_oe_n_o(data_pins_oe_n_o));

// ---- tb/host_bus_model.sv ----
// Host memory controller model driving the flash bus pins
`timescale 1ns/100ps
module host_bus_model (
	// Clock and answer
	input wire logic clk_i,
	input wire logic [flash_pkg::DATA_W-1:0] rdata_i,
	// Bus drive
	output logic link_clk_o,
	output logic address_valid_n_o,
	output logic first_select_n_o,
	output logic second_select_n_o,
	output logic output_enable_n_o,
	output logic write_enable_n_o,
	output logic [flash_pkg::ADDR_W-1:0] addr_o,
	output logic [flash_pkg::DATA_W-1:0] wdata_o
);
	import flash_pkg::*;
	initial begin
		link_clk_o = 1'b0;
		address_valid_n_o = 1'b1;
		first_select_n_o = 1'b1;
		second_select_n_o = 1'b1;
		output_enable_n_o = 1'b1;
		write_enable_n_o = 1'b1;
		addr_o = '0;
		wdata_o = '0;
	end
	// Link clock stays low outside bursts, also during unclocked reads
	task automatic async_read(input logic [ADDR_W-1:0] a, input logic s2,
		output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		if (s2) begin
			second_select_n_o <= 1'b0;
		end else begin
			first_select_n_o <= 1'b0;
		end
		address_valid_n_o <= 1'b0;
		output_enable_n_o <= 1'b0;
		addr_o <= a;
		repeat (6) @(posedge clk_i);
		d = rdata_i;
	endtask
	// Released lines are inverted so stale values never look valid
	task automatic release_bus;
		@(posedge clk_i);
		first_select_n_o <= 1'b1;
		second_select_n_o <= 1'b1;
		output_enable_n_o <= 1'b1;
		address_valid_n_o <= 1'b1;
		link_clk_o <= 1'b0;
		addr_o <= ~addr_o;
		wdata_o <= ~wdata_o;
	endtask
	task automatic write_word(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		first_select_n_o <= 1'b0;
		address_valid_n_o <= 1'b0;
		addr_o <= a;
		repeat (4) @(posedge clk_i);
		address_valid_n_o <= 1'b1;
		addr_o <= ~a;
		write_enable_n_o <= 1'b0;
		wdata_o <= d;
		repeat (4) @(posedge clk_i);
		write_enable_n_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		first_select_n_o <= 1'b1;
		wdata_o <= ~d;
	endtask
	task automatic burst_begin(input logic [ADDR_W-1:0] a);
		@(posedge clk_i);
		first_select_n_o <= 1'b0;
		address_valid_n_o <= 1'b0;
		addr_o <= a;
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b0;
		address_valid_n_o <= 1'b1;
		addr_o <= ~a;
		output_enable_n_o <= 1'b0;
	endtask
	// One link period of 160 ns, word taken at its end
	task automatic link_word(output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		link_clk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		d = rdata_i;
	endtask
endmodule // host_bus_model

// ---- tb/test_flash_device.sv ----
// Self-checking bench for the burst flash device
`timescale 1ns/100ps
module test_flash_device;
	import flash_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hw_reset_n = 1'b1;
	logic protect = 1'b1;
	burst_t burst_mode = BURST_CONT;
	logic link_clk, avd_n, sel1_n, sel2_n, oe_n, we_n, ready, oe_n_out;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, rd;
	int errors = 0;
	int n_tests = 0;
	always #10 clk = ~clk;
	flash_device i_dut (.clk_i(clk), .resetn_i(resetn),
		.link_clk_i(link_clk), .address_valid_n_i(avd_n),
		.first_select_n_i(sel1_n), .second_select_n_i(sel2_n),
		.output_enable_n_i(oe_n), .write_enable_n_i(we_n),
		.hw_reset_n_i(hw_reset_n), .protect_accel_in_i(protect),
		.ready_o(ready), .addr_i(addr), .data_pins_i(wdata),
		.data_pins_o(rdata), .data_pins_oe_n_o(oe_n_out),
		.burst_mode_i(burst_mode), .density_i(DENS_SMALL), .boot_top_i(1'b0));
	host_bus_model i_host (.clk_i(clk), .rdata_i(rdata),
		.link_clk_o(link_clk), .address_valid_n_o(avd_n),
		.first_select_n_o(sel1_n), .second_select_n_o(sel2_n),
		.output_enable_n_o(oe_n), .write_enable_n_o(we_n),
		.addr_o(addr), .wdata_o(wdata));
	task automatic check16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check1(input string what, input logic exp,
		input logic got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wait_ready;
		for (int i = 0; i < 40 && ready !== 1'b1; i++) begin
			@(posedge clk);
		end
		if (ready !== 1'b1) begin
			check1("ready wait", 1'b1, ready);
			give_verdict;
		end
	endtask
	task automatic t_async;
		i_host.async_read(25'h40, 1'b0, rd);
		check16("async word", ERASED_WORD, rd);
		check1("oe driven", 1'b0, oe_n_out);
		i_host.release_bus;
		repeat (4) @(posedge clk);
		check1("oe released", 1'b1, oe_n_out);
	endtask
	task automatic t_protect;
		@(posedge clk);
		protect <= 1'b0;
		i_host.write_word(25'h40, 16'h0055);
		i_host.write_word(25'h40, PROG_KEY);
		repeat (40) @(posedge clk);
		protect <= 1'b1;
		i_host.async_read(25'h40, 1'b0, rd);
		check16("protected word", ERASED_WORD, rd);
		i_host.release_bus;
	endtask
	task automatic t_program;
		for (int i = 0; i < 8; i++) begin
			i_host.write_word(25'h10 + i, 16'h0100 + i);
		end
		i_host.write_word(25'h10, PROG_KEY);
		repeat (40) @(posedge clk);
		// Second select forces the top line, alias keeps the same word
		i_host.async_read(25'h13, 1'b1, rd);
		check16("programmed word", 16'h0103, rd);
		i_host.release_bus;
	endtask
	task automatic t_wrap(input burst_t m, input int len,
		input logic [ADDR_W-1:0] start);
		int off;
		@(posedge clk);
		burst_mode <= m;
		i_host.burst_begin(start);
		wait_ready;
		// Stall so the prefetch fills the buffer until it refuses
		repeat (20) @(posedge clk);
		check1("ready stalled", 1'b1, ready);
		for (int i = 0; i < len; i++) begin
			off = (int'(start[3:0]) + i) % len;
			i_host.link_word(rd);
			check16("wrap word", off < 8 ? 16'h0100 + off[15:0] :
				ERASED_WORD, rd);
		end
		repeat (4) @(posedge clk);
		check1("ready after wrap", 1'b0, ready);
		i_host.release_bus;
	endtask
	task automatic t_erase;
		i_host.write_word(25'h10, ERASE_KEY);
		i_host.async_read(25'h12, 1'b0, rd);
		check16("busy bank word", BUSY_READ_WORD, rd);
		i_host.release_bus;
		i_host.async_read(25'h83ff0, 1'b0, rd);
		check16("other bank word", ERASED_WORD, rd);
		i_host.release_bus;
		repeat (17000) @(posedge clk);
		i_host.async_read(25'h12, 1'b0, rd);
		check16("erased word", ERASED_WORD, rd);
		i_host.release_bus;
	endtask
	task automatic t_hw_reset;
		@(posedge clk);
		burst_mode <= BURST_CONT;
		i_host.burst_begin(25'h20);
		wait_ready;
		i_host.link_word(rd);
		check16("continuous word", ERASED_WORD, rd);
		@(posedge clk);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		check1("ready in reset", 1'b0, ready);
		hw_reset_n <= 1'b1;
		i_host.release_bus;
		repeat (4) @(posedge clk);
		i_host.async_read(25'h13, 1'b0, rd);
		check16("read after reset", ERASED_WORD, rd);
		i_host.release_bus;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		t_async;
		t_protect;
		t_program;
		t_wrap(BURST_WRAP8, WRAP8_LEN, 25'h13);
		t_wrap(BURST_WRAP16, WRAP16_LEN, 25'h12);
		t_erase;
		t_hw_reset;
		give_verdict;
	end
endmodule // test_flash_device
